// *** include/fes_link_if.sv ***
// Four-wire serial link between the flash sequencer and its host controller.
interface fes_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  modport dev(input cs_n, input sck, input si, output so);
  modport host(output cs_n, output sck, output si, input so);
endinterface

// *** include/fes_pkg.sv ***
// Shared constants, types and decode helpers for the erase and suspend sequencer link.
package fes_pkg;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_ERASE_SMALL = 8'h20;
  localparam logic [7:0] OP_ERASE_MID = 8'h52;
  localparam logic [7:0] OP_ERASE_LARGE = 8'hd8;
  localparam logic [7:0] OP_ERASE_FULL_A = 8'hc7;
  localparam logic [7:0] OP_ERASE_FULL_B = 8'h60;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_PROG_QUAD = 8'h33;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;

  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned SMALL_ERASE_TIME_US = 1000;
  localparam int unsigned MID_ERASE_TIME_US = 2000;
  localparam int unsigned LARGE_ERASE_TIME_US = 3000;
  localparam int unsigned FULL_ERASE_TIME_US = 10000;
  localparam int unsigned PROG_TIME_US = 500;
  localparam int unsigned PAUSE_LATENCY_US = 20;
  localparam int unsigned RESUME_LATENCY_NS = 200;
  localparam int unsigned SMALL_ERASE_CYC = SMALL_ERASE_TIME_US * CLK_MHZ;
  localparam int unsigned MID_ERASE_CYC = MID_ERASE_TIME_US * CLK_MHZ;
  localparam int unsigned LARGE_ERASE_CYC = LARGE_ERASE_TIME_US * CLK_MHZ;
  localparam int unsigned FULL_ERASE_CYC = FULL_ERASE_TIME_US * CLK_MHZ;
  localparam int unsigned PROG_CYC = PROG_TIME_US * CLK_MHZ;
  localparam int unsigned PAUSE_LATENCY_CYC = PAUSE_LATENCY_US * CLK_MHZ;
  localparam int unsigned RESUME_LATENCY_CYC = (RESUME_LATENCY_NS * CLK_MHZ) / 1000;

  localparam int unsigned ADDR_W = 24;
  localparam logic [23:0] SMALL_BLK_BYTES = 24'h001000;
  localparam logic [23:0] MID_BLK_BYTES = 24'h008000;
  localparam logic [23:0] LARGE_BLK_BYTES = 24'h010000;
  localparam logic [15:0] BITS_OPCODE = 16'h0008;
  localparam logic [15:0] BITS_ADDR_CMD = 16'h0020;
  localparam logic [15:0] BITS_MIN_PROG = 16'h0028;
  localparam int unsigned SR1_BUSY_BIT = 0;
  localparam int unsigned SR1_LATCH_BIT = 1;
  localparam int unsigned SR2_HALT_BIT = 7;
  localparam int unsigned HOST_HALF_CYC = 4;
  localparam int unsigned HOST_GAP_CYC = 8;

  typedef enum logic [2:0] {
    FES_OP_NONE = 3'b000,
    FES_OP_SMALL = 3'b001,
    FES_OP_MID = 3'b010,
    FES_OP_LARGE = 3'b011,
    FES_OP_FULL = 3'b100,
    FES_OP_PROG = 3'b101
  } fes_op_e;

  // Maps an opcode onto the self-timed operation it starts, or none.
  function automatic fes_op_e fes_kind(input logic [7:0] op);
    fes_op_e k;
    k = FES_OP_NONE;
    if (op == OP_ERASE_SMALL)
      k = FES_OP_SMALL;
    else if (op == OP_ERASE_MID)
      k = FES_OP_MID;
    else if (op == OP_ERASE_LARGE)
      k = FES_OP_LARGE;
    else if (op == OP_ERASE_FULL_A || op == OP_ERASE_FULL_B)
      k = FES_OP_FULL;
    else if (op == OP_PROG || op == OP_PROG_QUAD)
      k = FES_OP_PROG;
    return k;
  endfunction
endpackage

// *** verif/fes_link_asserts.sv ***
// Concurrent checks on the serial link and the device status outputs.
module fes_link_asserts
  import fes_pkg::*;
#(
  parameter int unsigned PAUSE_CYC = PAUSE_LATENCY_CYC
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic busy,
  input wire logic write_enable_latch,
  input wire logic halt_pending_flag,
  input wire logic op_start,
  input wire fes_op_e op_kind,
  input wire logic op_done
);
  // Two spare cycles cover the register stages between the flag and busy.
  localparam int unsigned PAUSE_MAX = PAUSE_CYC + 2;
  logic sck_q;
  logic [5:0] bit_cnt_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  always_ff @(posedge clk)
  begin
    if (!nrst)
      sck_q <= 1'b0;
    else
      sck_q <= sck;
  end

  // Only the low three bits matter, so long frames may wrap the count.
  always_ff @(posedge clk)
  begin
    if (!nrst || cs_n)
      bit_cnt_q <= 6'h00;
    else if (sck && !sck_q)
      bit_cnt_q <= bit_cnt_q + 6'h01;
  end

  sequence fresh_start;
    !busy && !halt_pending_flag ##1 busy;
  endsequence
  sequence run_ends;
    busy && !halt_pending_flag ##1 !busy && !halt_pending_flag;
  endsequence

  frame_bytes_a: assert property ($rose(cs_n) |-> bit_cnt_q[2:0] == 3'h0)
    else $error("frame ended off a byte boundary");
  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("serial clock moved outside a frame");
  start_pulse_a: assert property (fresh_start |-> op_start)
    else $error("operation start pulse missing");
  latch_clear_a: assert property ($rose(busy) |-> !write_enable_latch)
    else $error("latch still set while busy rose");
  latch_need_a: assert property ($rose(busy) && !$past(halt_pending_flag)
    |-> $past(write_enable_latch))
    else $error("run began without the latch");
  done_pulse_a: assert property (run_ends |-> op_done)
    else $error("completion pulse missing");
  done_cause_a: assert property (op_done |-> !busy && $past(busy, 2))
    else $error("completion pulse without a finished run");
  halt_busy_a: assert property ($rose(halt_pending_flag) |-> $past(busy))
    else $error("suspend taken while idle");
  full_no_halt_a: assert property (op_kind == FES_OP_FULL |-> !halt_pending_flag)
    else $error("full erase was suspended");
  pause_bound_a: assert property ($rose(halt_pending_flag) |-> ##[1:PAUSE_MAX] !busy)
    else $error("busy stayed high after suspend");
  resume_busy_a: assert property ($fell(halt_pending_flag) |-> busy)
    else $error("resume did not raise busy");
endmodule // fes_link_asserts

// *** verif/flash_erase_suspend_sequencer_bench.sv ***
// Bench joining host and device ends, plus a bench-driven device for framing faults.
module flash_erase_suspend_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import fes_pkg::*;
  localparam int unsigned PAUSE = 20;
  localparam int unsigned SMALL_T = 200;
  localparam int unsigned MID_T = 300;
  localparam int unsigned LARGE_T = 400;
  localparam int unsigned FULL_T = 600;
  localparam int unsigned PGM_T = 150;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_op = 8'h00;
  logic [23:0] cmd_addr = 24'h000000;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ready, rsp_valid, busy, we_latch, halt, op_start, op_done, busy_b, we_latch_b;
  logic [7:0] rsp_data;
  logic [23:0] op_base, base_b;
  fes_op_e op_kind, kind_b;
  int err_total = 0;
  int samples_checked = 0;
  logic [26:0] q_op[$];
  logic [15:0] q_rsp[$];
  logic [7:0] ers[5] = '{OP_ERASE_SMALL, OP_ERASE_MID, OP_ERASE_LARGE, OP_ERASE_FULL_A,
    OP_ERASE_FULL_B};
  fes_link_if lk();
  fes_link_if lk_b();

  fes_host #(.PAUSE_CYC(PAUSE)) i_fes_host (.clk(clk), .nrst(nrst), .link(lk.host),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  fes_dev #(.SMALL_CYC(SMALL_T), .MID_CYC(MID_T), .LARGE_CYC(LARGE_T), .FULL_CYC(FULL_T),
    .PGM_CYC(PGM_T), .PAUSE_CYC(PAUSE)) i_fes_dev (.clk(clk), .nrst(nrst), .link(lk.dev),
    .busy(busy), .write_enable_latch(we_latch), .halt_pending_flag(halt), .op_start(op_start),
    .op_kind(op_kind), .op_base(op_base), .op_done(op_done));
  fes_dev #(.SMALL_CYC(SMALL_T), .PAUSE_CYC(PAUSE)) i_fes_dev_b (.clk(clk), .nrst(nrst),
    .link(lk_b.dev), .busy(busy_b), .write_enable_latch(we_latch_b), .halt_pending_flag(),
    .op_start(), .op_kind(kind_b), .op_base(base_b), .op_done());
  fes_link_asserts #(.PAUSE_CYC(PAUSE)) i_fes_link_asserts (.clk(clk), .nrst(nrst),
    .cs_n(lk.cs_n), .sck(lk.sck), .busy(busy), .write_enable_latch(we_latch),
    .halt_pending_flag(halt), .op_start(op_start), .op_kind(op_kind), .op_done(op_done));

  initial
  begin
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t ns: %s", $time, what);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic timeout(input string what);
    err_total++;
    $display("wrong value at %0t ns: %s", $time, what);
    stop_test();
  endtask

  // Holds the request until the edge that takes it, then drops it.
  task automatic send(input logic [7:0] op, input logic [23:0] a);
    int n;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= 8'($urandom);
    @(negedge clk);
    while (cmd_ready !== 1'b1)
    begin
      n++;
      if (n > 5000)
        timeout("host never ready");
      @(negedge clk);
    end
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] op, input logic [7:0] exp);
    q_rsp.push_back({op, exp});
    send(op, 24'h000000);
  endtask

  task automatic erase(input logic [7:0] op, input logic [23:0] a);
    logic [2:0] k;
    logic [23:0] m;
    case (op)
      OP_ERASE_SMALL: {k, m} = {FES_OP_SMALL, ~(SMALL_BLK_BYTES - 24'h000001)};
      OP_ERASE_MID: {k, m} = {FES_OP_MID, ~(MID_BLK_BYTES - 24'h000001)};
      OP_ERASE_LARGE: {k, m} = {FES_OP_LARGE, ~(LARGE_BLK_BYTES - 24'h000001)};
      OP_PROG: {k, m} = {FES_OP_PROG, 24'hffffff};
      default: {k, m} = {FES_OP_FULL, 24'h000000};
    endcase
    q_op.push_back({k, a & m});
    send(op, a);
  endtask

  task automatic wait_on(input int which, input string what);
    int n;
    n = 0;
    @(negedge clk);
    while (which == 0 ? op_done !== 1'b1 : q_rsp.size() != 0)
    begin
      n++;
      if (n > 3000)
        timeout(what);
      @(negedge clk);
    end
  endtask

  task automatic rst();
    nrst <= 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
  endtask

  // Frames the n low bits of v on the second link, most significant first.
  task automatic bang(input logic [31:0] v, input int n);
    @(posedge clk);
    lk_b.cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      lk_b.si <= v[i];
      repeat (HOST_HALF_CYC) @(posedge clk);
      lk_b.sck <= 1'b1;
      repeat (HOST_HALF_CYC) @(posedge clk);
      lk_b.sck <= 1'b0;
    end
    repeat (HOST_HALF_CYC) @(posedge clk);
    lk_b.cs_n <= 1'b1;
    lk_b.si <= ~v[0];
    repeat (HOST_GAP_CYC) @(posedge clk);
  endtask

  always @(negedge clk)
  begin
    logic [15:0] f;
    logic [26:0] e;
    if (op_start === 1'b1)
    begin
      e = q_op.size() ? q_op.pop_front() : 27'h7ffffff;
      check({op_kind, op_base}, e, "start");
    end
    if (rsp_valid === 1'b1)
    begin
      f = q_rsp.size() ? q_rsp.pop_front() : 16'h0003;
      if (f[15:8] == OP_RDSR2)
        check(rsp_data[SR2_HALT_BIT], f[7], "suspend flag");
      else
        check({rsp_data[SR1_LATCH_BIT], rsp_data[SR1_BUSY_BIT]}, f[1:0], "status");
    end
  end

  initial
  begin
    logic [23:0] a;
    void'($urandom(32'h6111293d));
    lk_b.cs_n = 1'b1;
    lk_b.sck = 1'b0;
    lk_b.si = 1'b0;
    rst();
    for (int i = 0; i < 5; i++)
    begin
      erase(ers[i], 24'($urandom));
      rd(OP_RDSR1, 8'h01);
      wait_on(0, "erase never ended");
      rd(OP_RDSR1, 8'h00);
      wait_on(1, "no status reply");
    end
    $display("test erase sizes done");
    // A second erase or program while suspended must not start anything.
    for (int i = 0; i < 2; i++)
    begin
      erase(i == 0 ? OP_ERASE_LARGE : OP_PROG, 24'($urandom));
      send(OP_SUSPEND, 24'h000000);
      rd(OP_RDSR2, 8'h80);
      rd(OP_RDSR1, 8'h00);
      send(i == 0 ? OP_ERASE_SMALL : OP_PROG_QUAD, 24'($urandom));
      send(OP_RESUME, 24'h000000);
      rd(OP_RDSR2, 8'h00);
      wait_on(0, "resumed run never ended");
      wait_on(1, "no status reply");
    end
    $display("test suspend and resume done");
    erase(OP_ERASE_FULL_A, 24'($urandom));
    send(OP_SUSPEND, 24'h000000);
    rd(OP_RDSR2, 8'h00);
    rd(OP_RDSR1, 8'h01);
    wait_on(0, "full erase never ended");
    wait_on(1, "no status reply");
    $display("test full erase suspend done");
    erase(OP_ERASE_MID, 24'($urandom));
    send(OP_SUSPEND, 24'h000000);
    rd(OP_RDSR2, 8'h80);
    wait_on(1, "no status reply");
    rst();
    rd(OP_RDSR2, 8'h00);
    rd(OP_RDSR1, 8'h00);
    wait_on(1, "no status reply");
    $display("test power loss done");
    a = 24'($urandom);
    bang(32'h00000006, 8);
    check(we_latch_b, 1'b1, "latch after enable");
    bang({8'h20, a} >> 1, 31);
    check(busy_b, 1'b0, "short frame ran");
    bang({8'h20, a}, 32);
    check(busy_b, 1'b1, "erase did not start");
    check(kind_b, FES_OP_SMALL, "block kind");
    check(base_b, a & ~(SMALL_BLK_BYTES - 24'h000001), "block base");
    repeat (SMALL_T - 10) @(posedge clk);
    check(busy_b, 1'b1, "erase ended early");
    repeat (20) @(posedge clk);
    check(busy_b, 1'b0, "erase ran long");
    bang({8'h20, a}, 32);
    check(busy_b, 1'b0, "erase ran without latch");
    $display("test framing faults done");
    stop_test();
  end
endmodule // flash_erase_suspend_sequencer_bench

// *** verilog/fes_dev.sv ***
// Flash-side erase, program-timing and suspend/resume command sequencer.
// What this block does; R6, R17 and R18 fall to fes_host, and R5 to the array outside
// (R1) 20h plus 24-bit address erases 4 kbyte block.
// (R2) 52h plus 24-bit address erases 32 kbyte block.
// (R3) D8h plus 24-bit address erases 64 kbyte block.
// (R4) C7h or 60h erases whole chip, no address.
// (R5) Every erase leaves its region all ones.
// (R6) Host sends write enable before each erase.
// (R7) Command runs only if frame ends on byte.
// (R8) Valid erase runs self-timed for its size.
// (R9) Status readable; busy high throughout, low after.
// (R10) Write enable latch clears when busy rises.
// (R11) 75h suspends running block erase or program.
// (R12) Suspend ignored during full-chip erase.
// (R13) Erase suspended: erases and status writes refused.
// (R14) Program suspended: programs, erases, status writes refused.
// (R15) Suspend taken only if not halted, busy.
// (R16) Suspend sets halt now, busy low within latency.
// (R17) Host waits pause latency after resume to suspend.
// (R18) Host distrusts reads near suspended region.
// (R19) Power loss clears halt pending flag.
// (R20) 7Ah resumes only if halted, idle; busy soon.
// (R21) Decoded write enable sets the latch.
// (R22) Erase without write enable latch is ignored.
// (R23) Block erase covers the aligned containing block.
module fes_dev
  import fes_pkg::*;
#(
  parameter int unsigned SMALL_CYC = SMALL_ERASE_CYC,
  parameter int unsigned MID_CYC = MID_ERASE_CYC,
  parameter int unsigned LARGE_CYC = LARGE_ERASE_CYC,
  parameter int unsigned FULL_CYC = FULL_ERASE_CYC,
  parameter int unsigned PGM_CYC = PROG_CYC,
  parameter int unsigned PAUSE_CYC = PAUSE_LATENCY_CYC
)
(
  input wire logic clk,
  input wire logic nrst,
  fes_link_if.dev link,
  output logic busy,
  output logic write_enable_latch,
  output logic halt_pending_flag,
  output logic op_start,
  output fes_op_e op_kind,
  output logic [23:0] op_base,
  output logic op_done
);
  logic [2:0] sck_sy_q, cs_sy_q;
  logic [1:0] si_sy_q;
  logic sck_rise, sck_fall, cs_rise, cs_low, si_bit, so_q, busy_q, halt_q, we_latch_q;
  logic start_q, done_q, len8, len_ok, wren_go, start_go, susp_go, res_go;
  logic [31:0] rx_q, remain_q, pause_q, run_cyc;
  logic [15:0] bitcnt_q;
  logic [7:0] op_q, op_now, out_sr_q;
  logic [23:0] addr_q, base_q, aligned;
  fes_op_e cur_q, kind_q, new_kind;

  // Pin synchronisers; stage 0 feeds only stage 1.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      sck_sy_q <= 3'h0;
      cs_sy_q <= 3'h7;
      si_sy_q <= 2'h0;
    end
    else
    begin
      sck_sy_q <= {sck_sy_q[1:0], link.sck};
      cs_sy_q <= {cs_sy_q[1:0], link.cs_n};
      si_sy_q <= {si_sy_q[0], link.si};
    end
  end

  assign sck_rise = sck_sy_q[1] & ~sck_sy_q[2];
  assign sck_fall = ~sck_sy_q[1] & sck_sy_q[2];
  assign cs_rise = cs_sy_q[1] & ~cs_sy_q[2];
  assign cs_low = ~cs_sy_q[1];
  assign si_bit = si_sy_q[1];
  assign op_now = (bitcnt_q == 16'h0007) ? {rx_q[6:0], si_bit} : op_q;

  // Frame shifter; the bit count saturates so long frames never wrap back onto a legal length.
  always_ff @(posedge clk)
  begin
    if (!nrst || !cs_low)
    begin
      rx_q <= 32'h0;
      bitcnt_q <= 16'h0;
    end
    else if (sck_rise)
    begin
      rx_q <= {rx_q[30:0], si_bit};
      if (bitcnt_q != 16'hffff)
        bitcnt_q <= bitcnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      op_q <= 8'h0;
      addr_q <= 24'h0;
    end
    else if (cs_low && sck_rise)
    begin
      if (bitcnt_q == 16'h0007)
        op_q <= {rx_q[6:0], si_bit};
      if (bitcnt_q == 16'h001f)
        addr_q <= {rx_q[22:0], si_bit}; // [R1] [R2] [R3]
    end
  end

  // Status stays readable in every state, so a busy poll works mid-operation.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      out_sr_q <= 8'h0;
      so_q <= 1'b0;
    end
    else if (cs_low && sck_rise && bitcnt_q[2:0] == 3'h7)
    begin
      out_sr_q <= 8'h0;
      if (op_now == OP_RDSR1)
      begin
        out_sr_q[SR1_BUSY_BIT] <= busy_q; // [R9]
        out_sr_q[SR1_LATCH_BIT] <= we_latch_q;
      end
      else if (op_now == OP_RDSR2)
        out_sr_q[SR2_HALT_BIT] <= halt_q;
    end
    else if (cs_low && sck_fall)
    begin
      so_q <= out_sr_q[7];
      out_sr_q <= {out_sr_q[6:0], 1'b0};
    end
  end

  assign new_kind = fes_kind(op_q);
  assign len8 = (bitcnt_q == BITS_OPCODE);

  always_comb
  begin
    len_ok = (bitcnt_q == BITS_ADDR_CMD); // [R7]
    run_cyc = 32'h0;
    aligned = 24'h0;
    unique case (new_kind)
      FES_OP_SMALL:
      begin
        run_cyc = SMALL_CYC;
        aligned = addr_q & ~(SMALL_BLK_BYTES - 24'h1); // [R23]
      end
      FES_OP_MID:
      begin
        run_cyc = MID_CYC;
        aligned = addr_q & ~(MID_BLK_BYTES - 24'h1); // [R23]
      end
      FES_OP_LARGE:
      begin
        run_cyc = LARGE_CYC;
        aligned = addr_q & ~(LARGE_BLK_BYTES - 24'h1); // [R23]
      end
      FES_OP_FULL:
      begin
        len_ok = len8; // [R4] [R7]
        run_cyc = FULL_CYC;
      end
      FES_OP_PROG:
      begin
        len_ok = (bitcnt_q >= BITS_MIN_PROG) && (bitcnt_q[2:0] == 3'h0);
        run_cyc = PGM_CYC;
        aligned = addr_q;
      end
      default: len_ok = 1'b0;
    endcase
  end

  assign wren_go = cs_rise && len8 && op_q == OP_WREN && !busy_q; // [R21]
  // Any erase or program is refused while busy or halted, which covers both suspend kinds.
  assign start_go = cs_rise && len_ok && we_latch_q && !busy_q && !halt_q; // [R13] [R14] [R22]
  assign susp_go = cs_rise && len8 && op_q == OP_SUSPEND && busy_q && !halt_q
    && cur_q != FES_OP_FULL && cur_q != FES_OP_NONE; // [R11] [R12] [R15]
  assign res_go = cs_rise && len8 && op_q == OP_RESUME && halt_q && !busy_q; // [R20]

  // Sequencer. Reset models power return, so a suspended operation is lost with its halt flag.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      busy_q <= 1'b0;
      halt_q <= 1'b0; // [R19]
      cur_q <= FES_OP_NONE;
      remain_q <= 32'h0;
      pause_q <= 32'h0;
    end
    else if (start_go)
    begin
      busy_q <= 1'b1; // [R8] [R9]
      cur_q <= new_kind;
      remain_q <= run_cyc;
    end
    else if (susp_go)
    begin
      halt_q <= 1'b1; // [R16]
      pause_q <= PAUSE_CYC;
    end
    else if (res_go)
    begin
      halt_q <= 1'b0; // [R20]
      busy_q <= 1'b1;
    end
    else if (busy_q && halt_q)
    begin
      if (pause_q <= 32'h1)
        busy_q <= 1'b0; // [R16]
      else
        pause_q <= pause_q - 32'h1;
    end
    else if (busy_q)
    begin
      if (remain_q <= 32'h1)
      begin
        busy_q <= 1'b0; // [R9]
        cur_q <= FES_OP_NONE;
      end
      else
        remain_q <= remain_q - 32'h1; // [R8]
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      we_latch_q <= 1'b0;
    else if (wren_go)
      we_latch_q <= 1'b1; // [R21]
    else if (start_go || res_go)
      we_latch_q <= 1'b0; // [R10]
  end

  // The array itself lies outside; it is told which aligned region to set to all ones.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      start_q <= 1'b0;
      done_q <= 1'b0;
      kind_q <= FES_OP_NONE;
      base_q <= 24'h0;
    end
    else
    begin
      start_q <= start_go;
      done_q <= busy_q && !halt_q && remain_q <= 32'h1;
      if (start_go)
      begin
        kind_q <= new_kind; // [R5]
        base_q <= aligned;
      end
    end
  end

  assign link.so = so_q;
  assign busy = busy_q;
  assign write_enable_latch = we_latch_q;
  assign halt_pending_flag = halt_q;
  assign op_start = start_q;
  assign op_kind = kind_q;
  assign op_base = base_q;
  assign op_done = done_q;
endmodule // fes_dev

// *** verilog/fes_host.sv ***
// Host-side serial controller that frames erase, suspend, resume and status commands.
module fes_host
  import fes_pkg::*;
#(
  parameter int unsigned HALF_CYC = HOST_HALF_CYC,
  parameter int unsigned GAP_CYC = HOST_GAP_CYC,
  parameter int unsigned PAUSE_CYC = PAUSE_LATENCY_CYC
)
(
  input wire logic clk,
  input wire logic nrst,
  fes_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_op,
  input wire logic [23:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  output logic rsp_valid,
  output logic [7:0] rsp_data
);
  typedef enum logic [1:0] {
    FES_H_IDLE = 2'b00,
    FES_H_SHIFT = 2'b01,
    FES_H_GAP = 2'b10
  } fes_hst_e;

  fes_hst_e st_q;
  logic [1:0] so_sy_q;
  logic [47:0] tx_q;
  logic [5:0] nbits_q;
  logic [5:0] bit_q;
  logic [7:0] ph_q;
  logic [15:0] gap_q;
  logic [31:0] hold_q;
  logic cs_n_q;
  logic sck_q;
  logic si_q;
  logic [7:0] rx_q;
  logic rd_q;
  logic res_q;
  logic pend_q;
  logic [47:0] ptx_q;
  logic [5:0] pn_q;
  logic prd_q;
  logic rsp_q;
  logic [7:0] rdat_q;
  logic [47:0] new_tx;
  logic [5:0] new_n;
  logic new_rd;
  logic fire;
  fes_op_e k;

  always_comb
  begin
    k = fes_kind(cmd_op);
    new_tx = {cmd_op, 40'h0};
    new_n = 6'd8;
    // Only status comes back; array data, which a suspended block may spoil, is never read.
    new_rd = (cmd_op == OP_RDSR1) || (cmd_op == OP_RDSR2); // [R18]
    if (new_rd)
      new_n = 6'd16;
    else if (k == FES_OP_PROG)
    begin
      new_tx = {cmd_op, cmd_addr, cmd_data, 8'h0};
      new_n = 6'd40;
    end
    else if (k != FES_OP_NONE && k != FES_OP_FULL)
    begin
      new_tx = {cmd_op, cmd_addr, 16'h0};
      new_n = 6'd32;
    end
  end

  assign cmd_ready = st_q == FES_H_IDLE && !(cmd_op == OP_SUSPEND && hold_q != 32'h0); // [R17]
  assign fire = cmd_valid && cmd_ready;

  always_ff @(posedge clk)
  begin
    if (!nrst)
      so_sy_q <= 2'h0;
    else
      so_sy_q <= {so_sy_q[0], link.so};
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      hold_q <= 32'h0;
    else if (st_q == FES_H_SHIFT && res_q && bit_q == nbits_q - 6'd1
      && ph_q == 8'(2 * HALF_CYC - 1))
      hold_q <= PAUSE_CYC; // [R17]
    else if (hold_q != 32'h0)
      hold_q <= hold_q - 32'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_q <= FES_H_IDLE;
      tx_q <= 48'h0;
      nbits_q <= 6'h0;
      bit_q <= 6'h0;
      ph_q <= 8'h0;
      gap_q <= 16'h0;
      cs_n_q <= 1'b1;
      sck_q <= 1'b0;
      si_q <= 1'b0;
      rx_q <= 8'h0;
      rd_q <= 1'b0;
      res_q <= 1'b0;
      pend_q <= 1'b0;
      ptx_q <= 48'h0;
      pn_q <= 6'h0;
      prd_q <= 1'b0;
      rsp_q <= 1'b0;
      rdat_q <= 8'h0;
    end
    else
    begin
      rsp_q <= 1'b0;
      unique case (st_q)
        FES_H_IDLE:
        begin
          if (fire)
          begin
            st_q <= FES_H_SHIFT;
            cs_n_q <= 1'b0;
            bit_q <= 6'h0;
            ph_q <= 8'h0;
            res_q <= cmd_op == OP_RESUME;
            if (k != FES_OP_NONE)
            begin
              tx_q <= {OP_WREN, 40'h0}; // [R6]
              nbits_q <= 6'd8;
              rd_q <= 1'b0;
              pend_q <= 1'b1;
              ptx_q <= new_tx;
              pn_q <= new_n;
              prd_q <= new_rd;
            end
            else
            begin
              tx_q <= new_tx;
              nbits_q <= new_n;
              rd_q <= new_rd;
            end
          end
        end
        FES_H_SHIFT:
        begin
          ph_q <= ph_q + 8'h1;
          if (ph_q == 8'h0)
            si_q <= tx_q[47];
          if (ph_q == 8'(HALF_CYC))
            sck_q <= 1'b1;
          if (ph_q == 8'(2 * HALF_CYC - 1))
          begin
            sck_q <= 1'b0;
            ph_q <= 8'h0;
            rx_q <= {rx_q[6:0], so_sy_q[1]};
            tx_q <= {tx_q[46:0], 1'b0};
            bit_q <= bit_q + 6'h1;
            // The frame closes right on the byte boundary so the command is executed.
            if (bit_q == nbits_q - 6'd1)
            begin
              cs_n_q <= 1'b1; // [R7]
              st_q <= FES_H_GAP;
              gap_q <= 16'(GAP_CYC);
              rsp_q <= rd_q;
              rdat_q <= {rx_q[6:0], so_sy_q[1]};
            end
          end
        end
        FES_H_GAP:
        begin
          if (gap_q > 16'h1)
            gap_q <= gap_q - 16'h1;
          else if (pend_q)
          begin
            pend_q <= 1'b0;
            st_q <= FES_H_SHIFT;
            cs_n_q <= 1'b0;
            bit_q <= 6'h0;
            ph_q <= 8'h0;
            tx_q <= ptx_q;
            nbits_q <= pn_q;
            rd_q <= prd_q;
          end
          else
            st_q <= FES_H_IDLE;
        end
        default:
        begin
          st_q <= FES_H_IDLE;
        end
      endcase
    end
  end

  assign link.cs_n = cs_n_q;
  assign link.sck = sck_q;
  assign link.si = si_q;
  assign rsp_valid = rsp_q;
  assign rsp_data = rdat_q;
endmodule // fes_host
